/* File: design/bsp_map.vh */
`ifndef BSP_MAP_VH
`define BSP_MAP_VH
// Peripheral bus word addresses (first port instance)
`define BSP_ADDR_RX_DATA_UPPER 8'h20
`define BSP_ADDR_RX_DATA_LOWER 8'h21
`define BSP_ADDR_TX_DATA_UPPER 8'h22
`define BSP_ADDR_TX_DATA_LOWER 8'h23
`define BSP_ADDR_SUBADDR 8'h38
`define BSP_ADDR_SUBDATA 8'h39
// Sub-addresses behind the shared data address
`define BSP_SUB_PORT_CTRL_ONE 4'h0
`define BSP_SUB_PORT_CTRL_TWO 4'h1
`define BSP_SUB_RX_CTRL_ONE 4'h2
`define BSP_SUB_RX_CTRL_TWO 4'h3
`define BSP_SUB_TX_CTRL_ONE 4'h4
`define BSP_SUB_TX_CTRL_TWO 4'h5
`define BSP_SUB_RATE_ONE 4'h6
`define BSP_SUB_RATE_TWO 4'h7
`define BSP_SUB_MCH_ONE 4'h8
`define BSP_SUB_MCH_TWO 4'h9
`define BSP_SUB_RX_CH_A 4'ha
`define BSP_SUB_RX_CH_B 4'hb
`define BSP_SUB_TX_CH_A 4'hc
`define BSP_SUB_TX_CH_B 4'hd
`define BSP_SUB_PIN_CTRL 4'he
`define BSP_SUB_LAST 4'he
// Field positions
`define BSP_RST_BIT 0
`define BSP_RDY_BIT 1
`define BSP_WLEN_LSB 5
`define BSP_WLEN_MSB 7
`define BSP_DIV_MSB 7
`define BSP_PIN_CLK_OUT_BIT 8
`define BSP_PIN_FRM_OUT_BIT 10
`define BSP_PIN_RX_CLK_OUT_BIT 9
`define BSP_PIN_RX_FRM_OUT_BIT 11
`define BSP_PIN_EXT_SOURCE_CLOCK_SEL_BIT 12
// Word length codes
`define BSP_WLEN_8 3'h0
`define BSP_WLEN_12 3'h1
`define BSP_WLEN_16 3'h2
`define BSP_WLEN_20 3'h3
`define BSP_WLEN_24 3'h4
`define BSP_WLEN_32 3'h5
// Reset values
`define BSP_REG_RESET 16'h0000
`define BSP_DIV_RESET 8'h03
`endif

/* File: design/bsp_sync.v */
`timescale 1ns/100ps
// Two-stage synchroniser for one pin
module bsp_sync (
    input wire clk_in, // System clock
    input wire reset_in, // Async reset
    input wire d_in, // Asynchronous level
    output reg q_out // Synchronised level
);
    reg meta_r;
    // First stage read only by second
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            meta_r <= 1'b0;
            q_out <= 1'b0;
        end else begin
            meta_r <= d_in;
            q_out <= meta_r;
        end
    end
endmodule

/* File: design/bsp_clkgen.v */
`timescale 1ns/100ps
// Internal bit clock and frame pulse generator
module bsp_clkgen #(
    parameter DIV_W = 8
) (
    input wire clk_in, // System clock
    input wire reset_in, // Async reset
    input wire run_in, // Generator enabled
    input wire [DIV_W-1:0] div_in, // Half period minus one
    input wire [5:0] bits_in, // Bits per frame minus one
    input wire src_in, // Synced external source clock
    input wire src_sel_in, // Count external source edges
    output reg bclk_out, // Generated bit clock
    output reg frame_out // Frame pulse, one bit long
);
    reg [DIV_W-1:0] cnt_r;
    reg [5:0] bit_r;
    reg src_d_r;
    wire tick;
    assign tick = src_sel_in ? (src_in & ~src_d_r) : 1'b1;
    // Divide, toggle, and count bits for frames
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            cnt_r <= {DIV_W{1'b0}};
            bit_r <= 6'h00;
            src_d_r <= 1'b0;
            bclk_out <= 1'b0;
            frame_out <= 1'b0;
        end else begin
            src_d_r <= src_in;
            if (!run_in) begin
                cnt_r <= {DIV_W{1'b0}};
                bit_r <= 6'h00;
                bclk_out <= 1'b0;
                frame_out <= 1'b0;
            end else if (tick) begin
                if (cnt_r == div_in) begin
                    cnt_r <= {DIV_W{1'b0}};
                    bclk_out <= ~bclk_out;
                    // Frame changes on falling edge so it is stable at rising
                    if (bclk_out) begin
                        frame_out <= (bit_r == 6'h00);
                        bit_r <= (bit_r == bits_in) ? 6'h00 : bit_r + 6'h01;
                    end
                end else begin
                    cnt_r <= cnt_r + {{(DIV_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule

/* File: design/bsp_core.v */
`timescale 1ns/100ps
`include "bsp_map.vh"
module bsp_core (
    input wire clk_in, // 250 MHz system clock
    input wire reset_in, // Async reset, active high
    input wire [7:0] bus_addr_in, // Peripheral bus word address
    input wire bus_wr_in, // Write strobe
    input wire bus_rd_in, // Read strobe
    input wire [15:0] bus_wdata_in, // Write data
    output reg [15:0] bus_rdata_out, // Read data, valid cycle after read
    output reg serial_data_out, // Transmit data pin
    output reg serial_data_oe_n_out, // Low while driving data pin
    input wire serial_data_in, // Receive data pin
    input wire ext_source_clock_in, // External clock pin
    input wire tx_bit_clock_in, // Transmit clock pin level
    output reg tx_bit_clock_out, // Transmit clock drive
    output reg tx_bit_clock_oe_n_out, // Low while driving
    input wire rx_bit_clock_in, // Receive clock pin level
    output reg rx_bit_clock_out, // Receive clock drive
    output reg rx_bit_clock_oe_n_out, // Low while driving
    input wire tx_frame_pulse_in, // Transmit frame pin level
    output reg tx_frame_pulse_out, // Transmit frame drive
    output reg tx_frame_pulse_oe_n_out, // Low while driving
    input wire rx_frame_pulse_in, // Receive frame pin level
    output reg rx_frame_pulse_out, // Receive frame drive
    output reg rx_frame_pulse_oe_n_out, // Low while driving
    output reg rx_irq_out, // Receive interrupt pulse
    output reg tx_irq_out, // Transmit interrupt pulse
    output reg rx_dma_req_out, // Receive DMA event pulse
    output reg tx_dma_req_out, // Transmit DMA event pulse
    output reg rx_dma_req_alt_out, // Alternate receive DMA event pulse
    output reg tx_dma_req_alt_out // Alternate transmit DMA event pulse
);
    // Configuration registers
    reg [3:0] subaddr_r;
    reg [15:0] cfg_r [0:14];
    // Data registers as the bus sees them
    reg [15:0] tx_hi_r;
    reg [15:0] tx_lo_r;
    reg [15:0] rx_hi_r;
    reg [15:0] rx_lo_r;
    // Shifters and buffer, unreachable from the bus
    reg [31:0] tx_shifter_r;
    reg [31:0] rx_shifter_r;
    reg [31:0] rx_buffer_r;
    // Flags between bus side and link side
    reg tx_full_r;
    reg tx_busy_r;
    reg tx_frame_pend_r;
    reg rx_buf_full_r;
    reg rx_rdy_r;
    reg rx_overrun_r;
    reg rx_act_r;
    // Bit counters and clock history
    reg [5:0] tx_cnt_r;
    reg [5:0] rx_cnt_r;
    reg tx_clk_d_r;
    reg rx_clk_d_r;
    integer i;
    // Views into the configuration words
    wire [15:0] port1 = cfg_r[`BSP_SUB_PORT_CTRL_ONE];
    wire [15:0] port2 = cfg_r[`BSP_SUB_PORT_CTRL_TWO];
    wire [15:0] pinc = cfg_r[`BSP_SUB_PIN_CTRL];
    wire rx_en = port1[`BSP_RST_BIT];
    wire tx_en = port2[`BSP_RST_BIT];
    wire [2:0] rx_wlen = cfg_r[`BSP_SUB_RX_CTRL_ONE][`BSP_WLEN_MSB:`BSP_WLEN_LSB];
    wire [2:0] tx_wlen = cfg_r[`BSP_SUB_TX_CTRL_ONE][`BSP_WLEN_MSB:`BSP_WLEN_LSB];
    // Length minus one per code
    function [5:0] wlen_bits;
        input [2:0] code;
        begin
            case (code)
                `BSP_WLEN_8: wlen_bits = 6'd7;
                `BSP_WLEN_12: wlen_bits = 6'd11;
                `BSP_WLEN_16: wlen_bits = 6'd15;
                `BSP_WLEN_20: wlen_bits = 6'd19;
                `BSP_WLEN_24: wlen_bits = 6'd23;
                `BSP_WLEN_32: wlen_bits = 6'd31;
                default: wlen_bits = 6'd31;
            endcase
        end
    endfunction
    wire [5:0] rx_last = wlen_bits(rx_wlen);
    wire [5:0] tx_last = wlen_bits(tx_wlen);
    // Upper halves only used beyond 16 bits
    wire rx_wide = rx_last > 6'd15;
    wire tx_wide = tx_last > 6'd15;
    // Synchronised pins
    wire dr_s;
    wire ext_source_clock_s;
    wire txc_s;
    wire rxc_s;
    wire txf_s;
    wire rxf_s;
    bsp_sync u_s_dr (.clk_in(clk_in), .reset_in(reset_in), .d_in(serial_data_in), .q_out(dr_s));
    bsp_sync u_s_cs (.clk_in(clk_in), .reset_in(reset_in), .d_in(ext_source_clock_in), .q_out(ext_source_clock_s));
    bsp_sync u_s_xc (.clk_in(clk_in), .reset_in(reset_in), .d_in(tx_bit_clock_in), .q_out(txc_s));
    bsp_sync u_s_rc (.clk_in(clk_in), .reset_in(reset_in), .d_in(rx_bit_clock_in), .q_out(rxc_s));
    bsp_sync u_s_xf (.clk_in(clk_in), .reset_in(reset_in), .d_in(tx_frame_pulse_in), .q_out(txf_s));
    bsp_sync u_s_rf (.clk_in(clk_in), .reset_in(reset_in), .d_in(rx_frame_pulse_in), .q_out(rxf_s));
    // Independent generators per direction
    wire gtx_clk;
    wire gtx_frm;
    wire grx_clk;
    wire grx_frm;
    bsp_clkgen #(.DIV_W(8)) u_gen_tx (
        .clk_in(clk_in), .reset_in(reset_in),
        .run_in(tx_en & pinc[`BSP_PIN_CLK_OUT_BIT]),
        .div_in(cfg_r[`BSP_SUB_RATE_ONE][`BSP_DIV_MSB:0]),
        .bits_in(tx_last), .src_in(ext_source_clock_s), .src_sel_in(pinc[`BSP_PIN_EXT_SOURCE_CLOCK_SEL_BIT]),
        .bclk_out(gtx_clk), .frame_out(gtx_frm));
    bsp_clkgen #(.DIV_W(8)) u_gen_rx (
        .clk_in(clk_in), .reset_in(reset_in),
        .run_in(rx_en & pinc[`BSP_PIN_RX_CLK_OUT_BIT]),
        .div_in(cfg_r[`BSP_SUB_RATE_TWO][`BSP_DIV_MSB:0]),
        .bits_in(rx_last), .src_in(ext_source_clock_s), .src_sel_in(pinc[`BSP_PIN_EXT_SOURCE_CLOCK_SEL_BIT]),
        .bclk_out(grx_clk), .frame_out(grx_frm));
    // Effective clock and frame per direction: internal or from pin
    wire tx_clk = pinc[`BSP_PIN_CLK_OUT_BIT] ? gtx_clk : txc_s;
    wire rx_clk = pinc[`BSP_PIN_RX_CLK_OUT_BIT] ? grx_clk : rxc_s;
    wire tx_frm = pinc[`BSP_PIN_FRM_OUT_BIT] ? gtx_frm : txf_s;
    wire rx_frm = pinc[`BSP_PIN_RX_FRM_OUT_BIT] ? grx_frm : rxf_s;
    // Edge detectors on the chosen clocks
    wire tx_rise = tx_clk & ~tx_clk_d_r;
    wire tx_fall = ~tx_clk & tx_clk_d_r;
    wire rx_fall = ~rx_clk & rx_clk_d_r;
    // Bus decode
    wire wr_sub = bus_wr_in & (bus_addr_in == `BSP_ADDR_SUBADDR);
    wire wr_cfg = bus_wr_in & (bus_addr_in == `BSP_ADDR_SUBDATA) & (subaddr_r <= `BSP_SUB_LAST);
    wire wr_txhi = bus_wr_in & (bus_addr_in == `BSP_ADDR_TX_DATA_UPPER) & tx_wide;
    wire wr_txlo = bus_wr_in & (bus_addr_in == `BSP_ADDR_TX_DATA_LOWER);
    wire rd_rxlo = bus_rd_in & (bus_addr_in == `BSP_ADDR_RX_DATA_LOWER);
    // Hand-over strobes; a pending word is never overwritten
    wire tx_load = tx_full_r & ~tx_busy_r & ~tx_frame_pend_r & tx_en;
    wire tx_word_end = tx_busy_r & tx_fall & (tx_cnt_r == tx_last);
    wire rx_word_end = rx_act_r & rx_fall & (rx_cnt_r == rx_last);
    wire rx_copy = rx_buf_full_r & ~rx_rdy_r;
    // Register writes through sub-address indirection
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            subaddr_r <= 4'h0;
            for (i = 0; i < 15; i = i + 1)
                cfg_r[i] <= `BSP_REG_RESET;
        end else begin
            if (wr_sub)
                subaddr_r <= bus_wdata_in[3:0];
            if (wr_cfg)
                cfg_r[subaddr_r] <= bus_wdata_in;
        end
    end
    // Read mux; status bits replace ready flags in port control one and two
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            bus_rdata_out <= 16'h0000;
        end else if (bus_rd_in) begin
            case (bus_addr_in)
                `BSP_ADDR_RX_DATA_UPPER: bus_rdata_out <= rx_wide ? rx_hi_r : 16'h0000;
                `BSP_ADDR_RX_DATA_LOWER: bus_rdata_out <= rx_lo_r;
                `BSP_ADDR_TX_DATA_UPPER: bus_rdata_out <= tx_hi_r;
                `BSP_ADDR_TX_DATA_LOWER: bus_rdata_out <= tx_lo_r;
                `BSP_ADDR_SUBADDR: bus_rdata_out <= {12'h000, subaddr_r};
                `BSP_ADDR_SUBDATA: begin
                    if (subaddr_r == `BSP_SUB_PORT_CTRL_ONE)
                        bus_rdata_out <= {port1[15:3], rx_overrun_r, rx_rdy_r, port1[0]};
                    else if (subaddr_r == `BSP_SUB_PORT_CTRL_TWO)
                        bus_rdata_out <= {port2[15:2], ~tx_full_r, port2[0]};
                    else if (subaddr_r <= `BSP_SUB_LAST)
                        bus_rdata_out <= cfg_r[subaddr_r];
                    else
                        bus_rdata_out <= 16'h0000;
                end
                default: bus_rdata_out <= 16'h0000;
            endcase
        end
    end
    // Transmit path: data register, shifter, pin
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            tx_hi_r <= 16'h0000;
            tx_lo_r <= 16'h0000;
            tx_full_r <= 1'b0;
            tx_busy_r <= 1'b0;
            tx_shifter_r <= 32'h0000_0000;
            tx_cnt_r <= 6'h00;
            tx_clk_d_r <= 1'b0;
            tx_frame_pend_r <= 1'b0;
            serial_data_out <= 1'b0;
            serial_data_oe_n_out <= 1'b1;
        end else begin
            tx_clk_d_r <= tx_clk;
            // Upper half only beyond 16 bits
            if (wr_txhi)
                tx_hi_r <= bus_wdata_in;
            // Lower half write completes the word; shifting continues
            if (wr_txlo) begin
                tx_lo_r <= bus_wdata_in;
                tx_full_r <= 1'b1;
            end else if (tx_load) begin
                tx_full_r <= 1'b0;
            end
            // Disabled transmitter floats the data pin
            if (!tx_en) begin
                tx_busy_r <= 1'b0;
                tx_frame_pend_r <= 1'b0;
                serial_data_oe_n_out <= 1'b1;
            end else begin
                if (tx_load) begin
                    // Left-align word so the MSB leaves first
                    tx_shifter_r <= ({tx_wide ? tx_hi_r : 16'h0000, tx_lo_r}) << (6'd31 - tx_last);
                    tx_frame_pend_r <= 1'b1;
                end
                if (tx_frame_pend_r & tx_rise & tx_frm) begin
                    tx_frame_pend_r <= 1'b0;
                    tx_busy_r <= 1'b1;
                    tx_cnt_r <= 6'h00;
                end
                // Drive next bit on falling clock edge
                if (tx_busy_r & tx_fall) begin
                    serial_data_out <= tx_shifter_r[31];
                    serial_data_oe_n_out <= 1'b0;
                    tx_shifter_r <= {tx_shifter_r[30:0], 1'b0};
                    tx_cnt_r <= tx_cnt_r + 6'h01;
                    if (tx_cnt_r == tx_last)
                        tx_busy_r <= 1'b0;
                end
            end
        end
    end
    // Receive path: shifter, buffer, data registers
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            rx_shifter_r <= 32'h0000_0000;
            rx_buffer_r <= 32'h0000_0000;
            rx_hi_r <= 16'h0000;
            rx_lo_r <= 16'h0000;
            rx_cnt_r <= 6'h00;
            rx_act_r <= 1'b0;
            rx_buf_full_r <= 1'b0;
            rx_rdy_r <= 1'b0;
            rx_overrun_r <= 1'b0;
            rx_clk_d_r <= 1'b0;
        end else begin
            rx_clk_d_r <= rx_clk;
            // Disabled receiver drops its flags
            if (!rx_en) begin
                rx_act_r <= 1'b0;
                rx_buf_full_r <= 1'b0;
                rx_rdy_r <= 1'b0;
                rx_overrun_r <= 1'b0;
            end else begin
                // Sample on falling edge of receive clock
                if (rx_fall) begin
                    if (!rx_act_r && rx_frm) begin
                        rx_act_r <= 1'b1;
                        rx_cnt_r <= 6'h01;
                        rx_shifter_r <= {31'h0000_0000, dr_s};
                    end else if (rx_act_r) begin
                        rx_shifter_r <= {rx_shifter_r[30:0], dr_s};
                        rx_cnt_r <= rx_cnt_r + 6'h01;
                        if (rx_cnt_r == rx_last)
                            rx_act_r <= 1'b0;
                    end
                end
                // Word complete moves to buffer; overrun if buffer still held
                if (rx_word_end) begin
                    if (rx_buf_full_r & ~rx_copy)
                        rx_overrun_r <= 1'b1;
                    else begin
                        rx_buffer_r <= {rx_shifter_r[30:0], dr_s};
                        rx_buf_full_r <= 1'b1;
                    end
                end else if (rx_copy) begin
                    rx_buf_full_r <= 1'b0;
                end
                if (rx_copy) begin
                    rx_lo_r <= rx_buffer_r[15:0];
                    if (rx_wide)
                        rx_hi_r <= rx_buffer_r[31:16];
                end
                // Ready set wins over read clear
                if (rx_copy)
                    rx_rdy_r <= 1'b1;
                else if (rd_rxlo)
                    rx_rdy_r <= 1'b0;
            end
        end
    end
    // Pin drives for clock and frame pins
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            tx_bit_clock_out <= 1'b0;
            tx_bit_clock_oe_n_out <= 1'b1;
            rx_bit_clock_out <= 1'b0;
            rx_bit_clock_oe_n_out <= 1'b1;
            tx_frame_pulse_out <= 1'b0;
            tx_frame_pulse_oe_n_out <= 1'b1;
            rx_frame_pulse_out <= 1'b0;
            rx_frame_pulse_oe_n_out <= 1'b1;
        end else begin
            tx_bit_clock_out <= gtx_clk;
            tx_bit_clock_oe_n_out <= ~pinc[`BSP_PIN_CLK_OUT_BIT];
            rx_bit_clock_out <= grx_clk;
            rx_bit_clock_oe_n_out <= ~pinc[`BSP_PIN_RX_CLK_OUT_BIT];
            tx_frame_pulse_out <= gtx_frm;
            tx_frame_pulse_oe_n_out <= ~pinc[`BSP_PIN_FRM_OUT_BIT];
            rx_frame_pulse_out <= grx_frm;
            rx_frame_pulse_oe_n_out <= ~pinc[`BSP_PIN_RX_FRM_OUT_BIT];
        end
    end
    // Event pulses to processor and DMA
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            rx_irq_out <= 1'b0;
            tx_irq_out <= 1'b0;
            rx_dma_req_out <= 1'b0;
            tx_dma_req_out <= 1'b0;
            rx_dma_req_alt_out <= 1'b0;
            tx_dma_req_alt_out <= 1'b0;
        end else begin
            rx_irq_out <= rx_copy;
            tx_irq_out <= tx_load;
            rx_dma_req_out <= rx_copy;
            tx_dma_req_out <= tx_load;
            rx_dma_req_alt_out <= rx_word_end & rx_overrun_r;
            tx_dma_req_alt_out <= tx_word_end;
        end
    end
endmodule

/* File: tb/bsp_core_properties.sv */
`timescale 1ns/100ps
// Port-level checks for the serial port core
module bsp_core_chk (
    input wire clk_in, // Clock
    input wire reset_in, // Reset
    input wire [7:0] bus_addr_in, // Address
    input wire bus_wr_in, // Write
    input wire bus_rd_in, // Read
    input wire [15:0] bus_wdata_in, // Write data
    input wire [15:0] bus_rdata_out, // Read data
    input wire serial_data_oe_n_out, // Data enable
    input wire tx_bit_clock_oe_n_out, // Tx clock enable
    input wire tx_frame_pulse_oe_n_out, // Tx frame enable
    input wire rx_irq_out, // Rx interrupt
    input wire tx_irq_out, // Tx interrupt
    input wire rx_dma_req_out, // Rx event
    input wire tx_dma_req_out, // Tx event
    input wire tx_dma_req_alt_out // Alternate tx event
);
    reg [15:0] sub_r; // Sub-address mirror
    reg [15:0] pin_r; // Pin control mirror
    // Follow sub-address and pin control writes
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            sub_r <= 16'h0000;
            pin_r <= 16'h0000;
        end else if (bus_wr_in) begin
            if (bus_addr_in == 8'h38)
                sub_r <= bus_wdata_in;
            if (bus_addr_in == 8'h39 && sub_r[3:0] == 4'he)
                pin_r <= bus_wdata_in;
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    chk_unmapped_zero: assert property (bus_rd_in && !(bus_addr_in inside {8'h20, 8'h21, 8'h22, 8'h23,
        8'h38, 8'h39}) |=> bus_rdata_out == 16'h0000) else $error("unmapped read not zero");
    chk_rdata_holds: assert property (!$past(bus_rd_in) |-> $stable(bus_rdata_out))
        else $error("read data moved without read");
    chk_rx_event_pair: assert property (rx_irq_out || rx_dma_req_out |-> rx_irq_out && rx_dma_req_out)
        else $error("rx interrupt and event apart");
    chk_tx_event_pair: assert property (tx_irq_out || tx_dma_req_out |-> tx_irq_out && tx_dma_req_out)
        else $error("tx interrupt and event apart");
    chk_rx_irq_pulse: assert property (rx_irq_out |=> !rx_irq_out) else $error("rx interrupt too long");
    chk_tx_irq_pulse: assert property (tx_irq_out |=> !tx_irq_out) else $error("tx interrupt too long");
    chk_alt_pulse: assert property (tx_dma_req_alt_out |=> !tx_dma_req_alt_out)
        else $error("alternate event too long");
    chk_reset_release: assert property ($past(reset_in) |-> serial_data_oe_n_out && tx_bit_clock_oe_n_out
        && !rx_irq_out && !tx_irq_out) else $error("outputs active after reset");
    chk_frame_input: assert property (!pin_r[10] && !$past(pin_r[10]) |-> tx_frame_pulse_oe_n_out)
        else $error("tx frame driven while input");
    chk_clock_input: assert property (!pin_r[8] && !$past(pin_r[8]) |-> tx_bit_clock_oe_n_out)
        else $error("tx clock driven while input");
endmodule
bind bsp_core bsp_core_chk i_bsp_core_chk (.clk_in, .reset_in, .bus_addr_in, .bus_wr_in, .bus_rd_in,
    .bus_wdata_in, .bus_rdata_out, .serial_data_oe_n_out, .tx_bit_clock_oe_n_out, .tx_frame_pulse_oe_n_out,
    .rx_irq_out, .tx_irq_out, .rx_dma_req_out, .tx_dma_req_out, .tx_dma_req_alt_out);

/* File: tb/bsp_peer.sv */
`timescale 1ns/100ps
// Far-side codec: one 8-bit frame each way
module bsp_peer (
    input wire start_in, // Start one frame
    input wire [7:0] rx_word_in, // Word sent to the port
    input wire tx_bit_in, // Port data pin level
    output reg clk_out, // Bit clock, still outside frames
    output reg frame_out, // Frame pulse
    output reg data_out, // Data toward the port
    output reg [7:0] tx_word_out, // Word captured
    output reg done_out // Frame finished
);
    integer i;
    initial begin
        clk_out = 1'b0;
        frame_out = 1'b0;
        data_out = 1'b1;
        tx_word_out = 8'h00;
        done_out = 1'b0;
    end
    // Frame high across the first rising and falling edge, MSB first
    always @(posedge start_in) begin
        done_out = 1'b0;
        frame_out = 1'b1;
        data_out = rx_word_in[7];
        for (i = 0; i < 10; i = i + 1) begin
            #52.5 clk_out = 1'b1;
            if (i >= 1 && i <= 8)
                tx_word_out = {tx_word_out[6:0], tx_bit_in};
            if (i >= 1)
                data_out = (i < 8) ? rx_word_in[7 - i] : ~data_out;
            #62.5 clk_out = 1'b0;
            #10 frame_out = 1'b0;
        end
        done_out = 1'b1;
    end
endmodule

/* File: tb/tb.sv */
`timescale 1ns/100ps
// Self-checking bench for the serial port core
module tb;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [7:0] bus_addr_in = 8'h00;
    logic bus_wr_in = 1'b0;
    logic bus_rd_in = 1'b0;
    logic [15:0] bus_wdata_in = 16'h0000;
    logic [15:0] bus_rdata_out;
    logic serial_data_out, serial_data_oe_n_out, tx_bit_clock_out, tx_bit_clock_oe_n_out, rx_bit_clock_out;
    logic rx_bit_clock_oe_n_out, tx_frame_pulse_out, tx_frame_pulse_oe_n_out, rx_frame_pulse_out;
    logic rx_frame_pulse_oe_n_out, rx_irq_out, tx_irq_out, rx_dma_req_out, tx_dma_req_out;
    logic rx_dma_req_alt_out, tx_dma_req_alt_out;
    logic peer_clk, peer_frm, peer_dat, peer_done, peer_go = 1'b0;
    logic [7:0] peer_tx;
    wire ext_source_clock_in = 1'b0;
    wire serial_data_in = peer_dat;
    wire tx_bit_clock_in = tx_bit_clock_oe_n_out ? peer_clk : tx_bit_clock_out;
    wire rx_bit_clock_in = rx_bit_clock_oe_n_out ? peer_clk : rx_bit_clock_out;
    wire tx_frame_pulse_in = tx_frame_pulse_oe_n_out ? peer_frm : tx_frame_pulse_out;
    wire rx_frame_pulse_in = rx_frame_pulse_oe_n_out ? peer_frm : rx_frame_pulse_out;
    wire line_bit = serial_data_oe_n_out ? ~serial_data_out : serial_data_out;
    int n_mismatch = 0;
    int check_count = 0;
    int n_rx = 0, n_rxd = 0, n_tx = 0, n_txd = 0, n_alt = 0, n_ralt = 0;
    bsp_core i_bsp_core (.clk_in, .reset_in, .bus_addr_in, .bus_wr_in, .bus_rd_in, .bus_wdata_in,
        .bus_rdata_out, .serial_data_out, .serial_data_oe_n_out, .serial_data_in, .ext_source_clock_in,
        .tx_bit_clock_in, .tx_bit_clock_out, .tx_bit_clock_oe_n_out, .rx_bit_clock_in, .rx_bit_clock_out,
        .rx_bit_clock_oe_n_out, .tx_frame_pulse_in, .tx_frame_pulse_out, .tx_frame_pulse_oe_n_out,
        .rx_frame_pulse_in, .rx_frame_pulse_out, .rx_frame_pulse_oe_n_out, .rx_irq_out, .tx_irq_out,
        .rx_dma_req_out, .tx_dma_req_out, .rx_dma_req_alt_out, .tx_dma_req_alt_out);
    bsp_peer i_bsp_peer (.start_in(peer_go), .rx_word_in(8'h3c), .tx_bit_in(line_bit), .clk_out(peer_clk),
        .frame_out(peer_frm), .data_out(peer_dat), .tx_word_out(peer_tx), .done_out(peer_done));
    // Clock
    always #2 clk_in = ~clk_in;
    // Event pulse counters
    always @(posedge clk_in) begin
        n_rx += (rx_irq_out === 1'b1);
        n_rxd += (rx_dma_req_out === 1'b1);
        n_tx += (tx_irq_out === 1'b1);
        n_txd += (tx_dma_req_out === 1'b1);
        n_alt += (tx_dma_req_alt_out === 1'b1);
        n_ralt += (rx_dma_req_alt_out === 1'b1);
    end
    task automatic chk16(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_in);
        bus_addr_in <= a;
        bus_wdata_in <= d;
        bus_wr_in <= 1'b1;
        @(posedge clk_in);
        bus_wr_in <= 1'b0;
    endtask
    task automatic chk_rd(input string name, input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_in);
        bus_addr_in <= a;
        bus_rd_in <= 1'b1;
        @(posedge clk_in);
        bus_rd_in <= 1'b0;
        @(posedge clk_in);
        #1 chk16(name, exp, bus_rdata_out);
    endtask
    task automatic wsub(input logic [15:0] s, input logic [15:0] d);
        wr(8'h38, s);
        wr(8'h39, d);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Configuration registers behind the shared address
    task automatic sc_regs;
        logic [3:0] subs[8] = '{4'h3, 4'h5, 4'h6, 4'h7, 4'ha, 4'hb, 4'hc, 4'hd};
        foreach (subs[k]) wsub({12'h000, subs[k]}, {subs[k], 12'h5a5});
        foreach (subs[k]) begin
            wr(8'h38, {12'h000, subs[k]});
            chk_rd("config", 8'h39, {subs[k], 12'h5a5});
        end
        chk_rd("subaddr", 8'h38, 16'h000d);
        chk_rd("unmapped", 8'h10, 16'h0000);
        wr(8'h22, 16'hbeef);
        chk_rd("tx_upper", 8'h22, 16'h0000);
    endtask
    // One word each way, bus busy during the frame
    task automatic sc_duplex;
        int t;
        wsub(16'h0002, 16'h0000);
        wsub(16'h0004, 16'h0000);
        wsub(16'h0000, 16'h0001);
        wsub(16'h0001, 16'h0001);
        wr(8'h23, 16'h00a5);
        @(posedge clk_in);
        peer_go <= 1'b1;
        wr(8'h38, 16'h0000);
        chk_rd("mid_frame", 8'h38, 16'h0000);
        for (t = 0; t < 2000 && peer_done !== 1'b1; t++) @(posedge clk_in);
        if (t == 2000)
            n_mismatch++;
        peer_go <= 1'b0;
        repeat (20) @(posedge clk_in);
        chk16("tx_word", 16'h00a5, {8'h00, peer_tx});
        chk_rd("ready_set", 8'h39, 16'h0003);
        chk_rd("rx_upper", 8'h20, 16'h0000);
        chk_rd("rx_lower", 8'h21, 16'h003c);
        chk_rd("ready_clr", 8'h39, 16'h0001);
        chk16("rx_irq", 16'd1, n_rx[15:0]);
        chk16("rx_dma", 16'd1, n_rxd[15:0]);
        chk16("tx_irq", 16'd1, n_tx[15:0]);
        chk16("tx_dma", 16'd1, n_txd[15:0]);
        chk16("tx_alt", 16'd1, n_alt[15:0]);
        chk16("rx_alt", 16'h0000, n_ralt[15:0]);
    endtask
    // Internal generator drives tx clock and frame pins
    task automatic sc_clkgen;
        int rises = 0;
        int frames = 0;
        logic pc = 1'b0;
        logic pf = 1'b0;
        wsub(16'h0006, 16'h0001);
        wsub(16'h000e, 16'h0500);
        repeat (40) @(negedge clk_in);
        repeat (64) begin
            pc = tx_bit_clock_out;
            pf = tx_frame_pulse_out;
            @(negedge clk_in);
            rises += (tx_bit_clock_out && !pc);
            frames += (tx_frame_pulse_out && !pf);
        end
        chk16("gen_clk", 16'h0010, rises[15:0]);
        chk16("gen_frame", 16'h0002, frames[15:0]);
        chk16("gen_drive", 16'h0000, {14'h0000, tx_bit_clock_oe_n_out, tx_frame_pulse_oe_n_out});
    endtask
    initial begin
        repeat (2) @(posedge clk_in);
        reset_in <= 1'b0;
        sc_regs();
        sc_duplex();
        sc_clkgen();
        end_sim();
    end
endmodule
